//--- shared/fcsl_cfg.svh
`ifndef FCSL_CFG_SVH
`define FCSL_CFG_SVH
// register byte offsets
`define FCSL_OFF_CTRL    12'h000
`define FCSL_OFF_CMD     12'h004
`define FCSL_OFF_STAT    12'h008
`define FCSL_OFF_PGWR    12'h01c
`define FCSL_OFF_LOCKSET 12'h020
// command word fields
`define FCSL_KEY_VALUE   8'ha5
`define FCSL_KEY_MSB     31
`define FCSL_KEY_LSB     24
`define FCSL_PAGE_MSB    23
`define FCSL_PAGE_LSB    8
`define FCSL_CODE_MSB    5
`define FCSL_CODE_LSB    0
// status bit positions
`define FCSL_ST_READY    0
`define FCSL_ST_LOCKERR  2
`define FCSL_ST_PROGERR  3
`define FCSL_ST_SECURE   4
`define FCSL_ST_QREAD    5
`define FCSL_ST_HSPEED   6
`define FCSL_ST_LOCK_LSB 16
// control bit positions (interrupt enables)
`define FCSL_CT_READY    0
`define FCSL_CT_LOCKERR  2
`define FCSL_CT_PROGERR  3
// reset values
`define FCSL_RST_CTRL    32'h0000_0000
`define FCSL_RST_CMD     32'h0000_0000
// operation timing
`define FCSL_OP_TIME_NS  1000
`define FCSL_CLK_NS      50
`define FCSL_OP_CYCLES   ((`FCSL_OP_TIME_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS)
`endif

//--- shared/fcsl_pkg.sv
package fcsl_pkg;
  typedef enum logic [4:0] {
    no_operation          = 5'h00,
    write_page            = 5'h01,
    erase_page            = 5'h02,
    clear_page_buffer     = 5'h03,
    lock_region           = 5'h04,
    unlock_region         = 5'h05,
    erase_all             = 5'h06,
    write_fuse_bit        = 5'h07,
    erase_fuse_bit        = 5'h08,
    set_security          = 5'h09,
    program_fuse_byte     = 5'h0a,
    erase_all_fuses       = 5'h0b,
    quick_page_check      = 5'h0c,
    write_user_page       = 5'h0d,
    erase_user_page       = 5'h0e,
    quick_user_page_check = 5'h0f,
    high_speed_on         = 5'h10,
    high_speed_off        = 5'h11
  } fcsl_cmd_t;
endpackage

//--- shared/fcsl_op_if.sv
`timescale 1ns/1ps
interface fcsl_op_if;
  logic       start;
  logic [4:0] code;
  logic       busy;
  logic       done;
  modport ctl (output start, output code, input busy, input done);
  modport seq (input start, input code, output busy, output done);
endinterface

//--- rtl/fcsl_cmd_check.sv
`timescale 1ns/1ps
`include "fcsl_cfg.svh"
module fcsl_cmd_check
  import fcsl_pkg::*;
(
  // command word under test
  input  wire logic [31:0] word,
  // verdict
  output logic             key_ok,
  output logic             code_ok
);
  // key check and code range check; codes 18..63 are unused
  always_comb begin
    key_ok  = (word[`FCSL_KEY_MSB:`FCSL_KEY_LSB] == `FCSL_KEY_VALUE);
    code_ok = (word[`FCSL_CODE_MSB:`FCSL_CODE_LSB] <= 6'h11);
  end
endmodule // fcsl_cmd_check

//--- rtl/fcsl_op_seq.sv
`timescale 1ns/1ps
`include "fcsl_cfg.svh"
module fcsl_op_seq
  import fcsl_pkg::*;
#(
  parameter int OP_CYCLES = `FCSL_OP_CYCLES
) (
  // system
  input  wire logic pclk,
  input  wire logic presetn,
  // operation handshake
  fcsl_op_if.seq    op
);
  typedef enum logic [0:0] {fcsl_idle, fcsl_run} fcsl_st_t;
  fcsl_st_t    st_q;
  logic [15:0] cnt_q;

  // stands in for the array timing: every accepted command except no_operation runs a fixed time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= fcsl_idle;
      cnt_q <= 16'h0000;
    end else begin
      case (st_q)
        fcsl_idle: if (op.start) begin
          st_q  <= fcsl_run;
          cnt_q <= 16'(OP_CYCLES - 1);
        end
        fcsl_run: if (cnt_q == 16'h0000) st_q <= fcsl_idle;
                  else cnt_q <= cnt_q - 16'h0001;
        default: st_q <= fcsl_idle;
      endcase
    end
  end
  assign op.busy = (st_q == fcsl_run);
  assign op.done = (st_q == fcsl_run) && (cnt_q == 16'h0000);
endmodule // fcsl_op_seq

//--- rtl/fcsl_top.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "fcsl_cfg.svh"
module fcsl_top
  import fcsl_pkg::*;
#(
  parameter int PAGE_BITS   = 10,
  parameter int PAGE_SHIFT  = 8,
  parameter int REGION_SPAN = 6,
  parameter int OP_CYCLES   = `FCSL_OP_CYCLES
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // page buffer write from the bus fabric
  input  wire logic        pbuf_wr,
  input  wire logic [31:0] pbuf_addr,
  // fuse and array inputs
  input  wire logic [15:0] lock_fuses,
  input  wire logic        page_erased,
  // operation outputs
  output logic             op_start,
  output logic [4:0]       op_code,
  output logic [15:0]      op_arg,
  output logic [7:0]       fuse_data,
  output logic [2:0]       fuse_addr,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  fcsl_op_if op ();
  fcsl_op_seq #(.OP_CYCLES(OP_CYCLES)) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .op      (op)
  );

  logic [31:0] ctrl_q;
  logic [15:0] page_q;
  logic [5:0]  code_q;
  logic        ready_q;
  logic        progerr_q;
  logic        lockerr_q;
  logic        secure_q;
  logic        hspeed_q;
  logic        qread_q;
  logic [15:0] lock_q;
  logic        lock_load_q;
  logic        ready_prev_q;
  logic        key_ok;
  logic        code_ok;

  function automatic logic [15:0] mask_page(input logic [15:0] v);
    mask_page = v & 16'((17'h1 << PAGE_BITS) - 17'h1);
  endfunction

  function automatic logic [3:0] region_of(input logic [15:0] pg);
    region_of = 4'(pg >> REGION_SPAN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: one-wait-free slave, answer in the access phase
  logic acc;
  logic wr_cmd;
  logic rd_stat;
  assign acc     = psel && penable;
  assign wr_cmd  = acc && pwrite && (paddr == `FCSL_OFF_CMD);
  assign rd_stat = acc && !pwrite && (paddr == `FCSL_OFF_STAT);

  fcsl_cmd_check u_chk (
    .word    (pwdata),
    .key_ok  (key_ok),
    .code_ok (code_ok)
  );

  logic accept;
  logic bad_cmd;
  // busy writes and bad key/code are refused; they only raise the error flag
  assign accept  = wr_cmd && key_ok && code_ok && ready_q;
  assign bad_cmd = wr_cmd && (!key_ok || !code_ok || !ready_q);

  always_comb begin
    op.start = accept && (pwdata[4:0] != 5'h00) && !pwdata[5];
    op.code  = pwdata[4:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= `FCSL_RST_CTRL;
    else if (acc && pwrite && paddr == `FCSL_OFF_CTRL) ctrl_q <= pwdata;
  end

  // page field: written by command, updated by page buffer writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) page_q <= 16'h0000;
    else if (accept) page_q <= mask_page(pwdata[`FCSL_PAGE_MSB:`FCSL_PAGE_LSB]);
    else if (pbuf_wr) page_q <= mask_page(16'(pbuf_addr >> PAGE_SHIFT));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) code_q <= 6'h00;
    else if (accept) code_q <= pwdata[`FCSL_CODE_MSB:`FCSL_CODE_LSB];
  end

  // ready falls the cycle after acceptance of a real operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ready_q <= 1'b1;
    else if (op.start) ready_q <= 1'b0;
    else if (op.done) ready_q <= 1'b1;
  end

  // set wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) progerr_q <= 1'b0;
    else if (bad_cmd) progerr_q <= 1'b1;
    else if (rd_stat) progerr_q <= 1'b0;
  end

  logic lock_hit;
  always_comb begin
    lock_hit = 1'b0;
    case (fcsl_cmd_t'(op.code))
      write_page, erase_page: lock_hit = lock_q[region_of(mask_page(pwdata[23:8]))];
      default: lock_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lockerr_q <= 1'b0;
    else if (op.start && lock_hit) lockerr_q <= 1'b1;
    else if (rd_stat) lockerr_q <= 1'b0;
  end

  // lock bits are loaded from fuses one cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q      <= 16'h0000;
      lock_load_q <= 1'b1;
    end else if (lock_load_q) begin
      lock_q      <= lock_fuses;
      lock_load_q <= 1'b0;
    end else if (op.start && op.code == lock_region)
      lock_q[region_of(mask_page(pwdata[23:8]))] <= 1'b1;
    else if (op.start && op.code == unlock_region)
      lock_q[region_of(mask_page(pwdata[23:8]))] <= 1'b0;
    else if (op.start && op.code == erase_all_fuses)
      lock_q <= 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) secure_q <= 1'b0;
    else if (op.start && op.code == set_security) secure_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hspeed_q <= 1'b0;
    else if (op.start && op.code == high_speed_on) hspeed_q <= 1'b1;
    else if (op.start && op.code == high_speed_off) hspeed_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) qread_q <= 1'b0;
    else if (op.done && (code_q[4:0] == quick_page_check || code_q[4:0] == quick_user_page_check))
      qread_q <= page_erased;
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation outputs towards the array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_start  <= 1'b0;
      op_code   <= 5'h00;
      op_arg    <= 16'h0000;
      fuse_data <= 8'h00;
      fuse_addr <= 3'h0;
    end else begin
      op_start <= op.start;
      if (op.start) begin
        op_code <= op.code;
        case (fcsl_cmd_t'(op.code))
          write_page, lock_region, unlock_region, quick_page_check,
          write_fuse_bit, erase_fuse_bit, erase_page:
            op_arg <= mask_page(pwdata[23:8]);
          default: op_arg <= 16'h0000;
        endcase
        if (op.code == program_fuse_byte) begin
          fuse_data <= pwdata[15:8];
          fuse_addr <= pwdata[18:16];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] stat;
  always_comb begin
    stat = 32'h0000_0000;
    stat[31:`FCSL_ST_LOCK_LSB] = lock_q;
    stat[`FCSL_ST_HSPEED]  = hspeed_q;
    stat[`FCSL_ST_QREAD]   = qread_q;
    stat[`FCSL_ST_SECURE]  = secure_q;
    stat[`FCSL_ST_PROGERR] = progerr_q;
    stat[`FCSL_ST_LOCKERR] = lockerr_q;
    stat[`FCSL_ST_READY]   = ready_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `FCSL_OFF_CTRL: prdata <= ctrl_q;
          `FCSL_OFF_CMD:  prdata <= {8'h00, page_q, 2'b00, code_q};
          `FCSL_OFF_STAT: prdata <= stat;
          default:        pslverr <= 1'b1;
        endcase
      end
    end
  end

  // interrupt from error flags and ready edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_prev_q <= 1'b1;
      irq          <= 1'b0;
    end else begin
      ready_prev_q <= ready_q;
      irq <= (progerr_q && ctrl_q[`FCSL_CT_PROGERR]) ||
             (lockerr_q && ctrl_q[`FCSL_CT_LOCKERR]) ||
             (ready_q && !ready_prev_q && ctrl_q[`FCSL_CT_READY]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_bad_key_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && !key_ok |=> progerr_q) else $error("bad key not flagged");
  a_key_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite && paddr == `FCSL_OFF_CMD |-> prdata[31:24] == 8'h00)
    else $error("key field not zero");
  a_page_masked: assert property (@(posedge pclk) disable iff (!presetn)
    mask_page(page_q) == page_q) else $error("page bits not masked");
  a_ready_drops: assert property (@(posedge pclk) disable iff (!presetn)
    op.start |=> !ready_q) else $error("ready did not drop");
  a_busy_write_err: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd && !ready_q |=> progerr_q && !op_start) else $error("busy write not refused");
  a_hs_on: assert property (@(posedge pclk) disable iff (!presetn)
    op.start && op.code == high_speed_on |=> hspeed_q) else $error("high speed not set");
  a_prog_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_stat && !bad_cmd |=> !progerr_q) else $error("status read did not clear");
  a_lock_err: assert property (@(posedge pclk) disable iff (!presetn)
    op.start && lock_hit |=> lockerr_q) else $error("lock error missed");
  a_ready_back: assert property (@(posedge pclk) disable iff (!presetn)
    op.done |=> ready_q) else $error("ready not restored");
endmodule // fcsl_top

//--- testbench/fcsl_top_tb.sv
`timescale 1ns/1ps
`include "fcsl_cfg.svh"
module fcsl_top_tb
  import fcsl_pkg::*;
;
  typedef struct packed {
    logic [4:0]  code;
    logic [15:0] arg;
    logic [31:0] st;
    logic [31:0] msk;
  } fcsl_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pbuf_wr, page_erased, op_start, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pbuf_addr, rd;
  logic [15:0] lock_fuses, op_arg, last_arg;
  logic [4:0]  op_code, last_code;
  logic [7:0]  fuse_data;
  logic [2:0]  fuse_addr;
  logic [10:0] last_fuse;
  logic        er, seen;
  int          err_count, total_checks, starts, s, cyc;
  fcsl_row_t   rows [18];

  fcsl_top #(.OP_CYCLES(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pbuf_wr(pbuf_wr), .pbuf_addr(pbuf_addr), .lock_fuses(lock_fuses), .page_erased(page_erased),
    .op_start(op_start), .op_code(op_code), .op_arg(op_arg), .fuse_data(fuse_data),
    .fuse_addr(fuse_addr), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // hang guard: whole run needs well under this many cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      end_of_test();
    end
  end

  always @(posedge pclk) begin
    if (op_start === 1'b1) begin
      starts    <= starts + 1;
      last_code <= op_code;
      last_arg  <= op_arg;
      last_fuse <= {fuse_addr, fuse_data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one edge of idle follows every transfer so no signal is assigned twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      apb(1'b0, `FCSL_OFF_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 30);
  endtask

  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // page 0x345 sits in region 13; region 0 is locked by fuse
    rows = '{'{5'h00, 16'h0000, 32'h0001_0001, 32'hffff_ffff}, '{5'h01, 16'h0345, 32'h0001_0001, 32'hffff_ffff},
             '{5'h02, 16'hffff, 32'h0001_0001, 32'hffff_ffff}, '{5'h03, 16'h0000, 32'h0001_0001, 32'hffff_ffff},
             '{5'h04, 16'h0345, 32'h2001_0001, 32'hffff_ffff}, '{5'h05, 16'h0345, 32'h0001_0001, 32'hffff_ffff},
             '{5'h06, 16'h0000, 32'h0000_0001, 32'h0000_006d}, '{5'h07, 16'h0345, 32'h0000_0001, 32'h0000_006d},
             '{5'h08, 16'h0345, 32'h0000_0001, 32'h0000_006d}, '{5'h09, 16'h0000, 32'h0000_0011, 32'h0000_007d},
             '{5'h0a, 16'hffff, 32'h0000_0001, 32'h0000_006d}, '{5'h0b, 16'h0000, 32'h0000_0001, 32'h0000_006d},
             '{5'h0c, 16'h0345, 32'h0000_0021, 32'h0000_006d}, '{5'h0d, 16'h0000, 32'h0000_0021, 32'h0000_006d},
             '{5'h0e, 16'h0000, 32'h0000_0021, 32'h0000_006d}, '{5'h0f, 16'h0000, 32'h0000_0021, 32'h0000_006d},
             '{5'h10, 16'h0000, 32'h0000_0061, 32'h0000_006d}, '{5'h11, 16'h0000, 32'h0000_0021, 32'h0000_006d}};
    {psel, penable, pwrite, paddr, pwdata, pbuf_wr, pbuf_addr} = '0;
    {err_count, total_checks, starts, cyc} = '0;
    lock_fuses  = 16'h0001;
    page_erased = 1'b1;
    presetn     = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FCSL_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `FCSL_OFF_CMD, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `FCSL_OFF_STAT, 32'h0);
    chk(rd, 32'h0001_0001);
    for (int i = 0; i < 18; i++) begin
      s = starts;
      apb(1'b1, `FCSL_OFF_CMD, {8'ha5, 16'h0345, 3'h0, rows[i].code});
      apb(1'b0, `FCSL_OFF_CMD, 32'h0);
      chk(rd, {8'h00, 16'h0345, 3'h0, rows[i].code});
      wait_ready();
      chk(rd & rows[i].msk, rows[i].st & rows[i].msk);
      chk(32'(starts - s), {31'h0, rows[i].code != 5'h00});
      if (rows[i].code != 5'h00) chk({27'h0, last_code}, {27'h0, rows[i].code});
      if (rows[i].code != 5'h00 && rows[i].arg != 16'hffff) chk({16'h0, last_arg}, {16'h0, rows[i].arg});
      if (rows[i].code == 5'h0a) chk({21'h0, last_fuse}, {21'h0, 3'h3, 8'h45});
    end
    // wrong key, progerr interrupt masked
    s = starts;
    apb(1'b1, `FCSL_OFF_CMD, 32'h5a03_4501);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    chk(32'(starts - s), 32'h0);
    apb(1'b0, `FCSL_OFF_STAT, 32'h0);
    chk(rd & 32'h0d, 32'h09);
    apb(1'b0, `FCSL_OFF_STAT, 32'h0);
    chk(rd & 32'h0d, 32'h01);
    // reserved codes 18 and 31: the low end of the range and the top five-bit code
    apb(1'b1, `FCSL_OFF_CTRL, 32'h8);
    for (int c = 18; c < 32; c += 13) begin
      apb(1'b1, `FCSL_OFF_CMD, {8'ha5, 16'h0, 8'(c)});
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, `FCSL_OFF_STAT, 32'h0);
      chk(rd & 32'h0d, 32'h09);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
    end
    // command while busy
    apb(1'b1, `FCSL_OFF_CTRL, 32'h0);
    s = starts;
    apb(1'b1, `FCSL_OFF_CMD, 32'ha500_0003);
    apb(1'b1, `FCSL_OFF_CMD, 32'ha500_0001);
    apb(1'b0, `FCSL_OFF_STAT, 32'h0);
    chk(rd & 32'h0d, 32'h08);
    wait_ready();
    chk(32'(starts - s), 32'h1);
    // programming a locked region; erasing the fuses unlocked everything, so lock region 0 first
    apb(1'b1, `FCSL_OFF_CMD, 32'ha500_0504);
    wait_ready();
    apb(1'b1, `FCSL_OFF_CTRL, 32'h4);
    s = starts;
    apb(1'b1, `FCSL_OFF_CMD, 32'ha500_0501);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `FCSL_OFF_STAT, 32'h0);
    chk(rd & 32'h04, 32'h04);
    wait_ready();
    chk(rd & 32'h04, 32'h0);
    chk(32'(starts - s), 32'h1);
    // ready interrupt on completion
    apb(1'b1, `FCSL_OFF_CTRL, 32'h1);
    apb(1'b1, `FCSL_OFF_CMD, 32'ha500_0003);
    seen = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      if (irq === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
    // page buffer writes update the page field, masked to 10 bits
    pbuf_wr   <= 1'b1;
    pbuf_addr <= 32'h0001_2345;
    @(posedge pclk);
    pbuf_addr <= 32'hffff_ff00;
    @(posedge pclk);
    pbuf_wr <= 1'b0;
    @(posedge pclk);
    apb(1'b0, `FCSL_OFF_CMD, 32'h0);
    chk({16'h0, rd[23:8]}, 32'h03ff);
    pbuf_wr   <= 1'b1;
    pbuf_addr <= 32'h0001_2345;
    @(posedge pclk);
    pbuf_wr <= 1'b0;
    @(posedge pclk);
    apb(1'b0, `FCSL_OFF_CMD, 32'h0);
    chk({16'h0, rd[23:8]}, 32'h0123);
    apb(1'b1, `FCSL_OFF_CMD, 32'ha5ff_ff00);
    apb(1'b0, `FCSL_OFF_CMD, 32'h0);
    chk(rd, 32'h0003_ff00);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
    end_of_test();
  end
endmodule // fcsl_top_tb
